// ==== src/sarseq_defs.vh ====
`ifndef SARSEQ_DEFS_VH
`define SARSEQ_DEFS_VH

// Resolution select codes
`define SARSEQ_RES_8 2'h0
`define SARSEQ_RES_10 2'h1
`define SARSEQ_RES_12 2'h2
`define SARSEQ_RES_W8 4'h8
`define SARSEQ_RES_W10 4'hA
`define SARSEQ_RES_W12 4'hC

// Phase encodings
`define SARSEQ_ST_IDLE 3'h0
`define SARSEQ_ST_DISCH 3'h1
`define SARSEQ_ST_ACQ 3'h2
`define SARSEQ_ST_GND 3'h3
`define SARSEQ_ST_TRIAL 3'h4
`define SARSEQ_ST_DONE 3'h5

// Default phase lengths in converter clocks
`define SARSEQ_DISCH_CYC 8'h01
`define SARSEQ_ACQ_CYC 8'h10

`endif

// ==== src/sarseq_sync.v ====
`timescale 1ns/100ps
`default_nettype none

module sarseq_sync (
  input wire clk_in,
  input wire sys_rst_in,
  input wire async_in,
  output wire sync_out
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

`default_nettype wire

// ==== src/sarseq_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "sarseq_defs.vh"

module sarseq_top #(
  parameter MAX_BITS = 12,
  // Phase lengths in converter clocks, one clock at the least
  parameter [7:0] DISCH_CYC = `SARSEQ_DISCH_CYC,
  parameter [7:0] ACQ_CYC = `SARSEQ_ACQ_CYC
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire start_in,
  input wire [1:0] res_sel_in,
  input wire comp_in,
  output reg discharge_out,
  output reg sample_out,
  output reg [MAX_BITS-1:0] cap_ref_out,
  output reg [MAX_BITS-1:0] result_out,
  output reg done_out,
  output reg busy_out
);

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg [3:0] bit_reg;
  reg [3:0] bit_next;
  reg [3:0] width_reg;
  reg [3:0] width_next;
  reg [MAX_BITS-1:0] trial_next;
  reg [MAX_BITS-1:0] result_next;
  reg discharge_next;
  reg sample_next;
  reg done_next;
  wire start_sync;
  wire last_trial;
  wire [MAX_BITS-1:0] trial_mask;
  wire [MAX_BITS-1:0] settled_trial;

  // Start may come from a pin or another clock, so it is synchronised;
  // the price is two clocks of latency before discharge begins
  sarseq_sync u_start_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(start_in),
    .sync_out(start_sync)
  );

  // Maps a resolution select to a bit count; unused code falls back to 12
  function [3:0] res_width;
    input [1:0] sel;
    begin
      if (sel == `SARSEQ_RES_8) begin
        res_width = `SARSEQ_RES_W8;
      end else if (sel == `SARSEQ_RES_10) begin
        res_width = `SARSEQ_RES_W10;
      end else begin
        res_width = `SARSEQ_RES_W12;
      end
    end
  endfunction

  // One-hot mask of a capacitor index
  function [MAX_BITS-1:0] bit_mask;
    input [3:0] idx;
    begin
      bit_mask = {{(MAX_BITS-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  // Load value of a phase counter; a zero length would wrap around
  function [7:0] phase_load;
    input [7:0] len;
    begin
      phase_load = len - 8'h01;
    end
  endfunction

  // A phase ends on the clock at which its counter has run down
  function phase_over;
    input [7:0] cnt;
    begin
      phase_over = (cnt == 8'h00);
    end
  endfunction

  // The comparator is latched on the converter clock, so it is read directly;
  // a synchroniser would cost two clocks on every bit trial
  assign last_trial = (bit_reg == 4'h0);
  assign trial_mask = bit_mask(bit_reg);
  // rejected bit returns its capacitor to ground
  assign settled_trial = comp_in ? cap_ref_out : (cap_ref_out & ~trial_mask);

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    width_next = width_reg;
    trial_next = cap_ref_out;
    result_next = result_out;
    discharge_next = 1'b0;
    sample_next = 1'b0;
    done_next = 1'b0;
    case (state_reg)
      `SARSEQ_ST_IDLE: begin
        if (start_sync) begin
          // latch resolution; it must be steady while start is pending
          width_next = res_width(res_sel_in);
          state_next = `SARSEQ_ST_DISCH;
          discharge_next = 1'b1;
          cnt_next = phase_load(DISCH_CYC);
          // Array is grounded while the discharge switch is closed
          trial_next = {MAX_BITS{1'b0}};
        end
      end
      `SARSEQ_ST_DISCH: begin
        // Discharge is held for its whole count
        if (phase_over(cnt_reg)) begin
          state_next = `SARSEQ_ST_ACQ;
          sample_next = 1'b1;
          cnt_next = phase_load(ACQ_CYC);
        end else begin
          discharge_next = 1'b1;
          cnt_next = cnt_reg - 8'h01;
        end
      end
      `SARSEQ_ST_ACQ: begin
        // Input stays on every capacitor for the whole count
        if (phase_over(cnt_reg)) begin
          // all capacitors to ground, one clock
          state_next = `SARSEQ_ST_GND;
          trial_next = {MAX_BITS{1'b0}};
        end else begin
          sample_next = 1'b1;
          cnt_next = cnt_reg - 8'h01;
        end
      end
      `SARSEQ_ST_GND: begin
        state_next = `SARSEQ_ST_TRIAL;
        bit_next = width_reg - 4'h1;
        trial_next = bit_mask(width_reg - 4'h1);
        // Previous word stands until the array has been grounded
        result_next = {MAX_BITS{1'b0}};
      end
      `SARSEQ_ST_TRIAL: begin
        // registered decision sets the current bit
        // each decision lands one bit lower
        if (comp_in) begin
          result_next = result_out | trial_mask;
        end
        trial_next = settled_trial;
        if (last_trial) begin
          // ground plus N trials gives N+1 clocks
          // done rises with the final result bit
          state_next = `SARSEQ_ST_DONE;
          done_next = 1'b1;
        end else begin
          bit_next = bit_reg - 4'h1;
          trial_next = settled_trial | bit_mask(bit_reg - 4'h1);
        end
      end
      `SARSEQ_ST_DONE: begin
        // busy still covers this cycle, so a start waits for idle
        state_next = `SARSEQ_ST_IDLE;
      end
      default: begin
        state_next = `SARSEQ_ST_IDLE;
      end
    endcase
  end

  // Every output is a flip-flop; no pin is reached through gates
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= `SARSEQ_ST_IDLE;
      cnt_reg <= 8'h00;
      bit_reg <= 4'h0;
      width_reg <= `SARSEQ_RES_W12;
      // Array rests on ground after reset
      cap_ref_out <= {MAX_BITS{1'b0}};
      result_out <= {MAX_BITS{1'b0}};
      discharge_out <= 1'b0;
      sample_out <= 1'b0;
      done_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      width_reg <= width_next;
      cap_ref_out <= trial_next;
      result_out <= result_next;
      discharge_out <= discharge_next;
      sample_out <= sample_next;
      done_out <= done_next;
      // Busy stays high through the done pulse
      busy_out <= (state_next != `SARSEQ_ST_IDLE);
    end
  end

endmodule

`default_nettype wire

// ==== tb/sarseq_top_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module sarseq_top_props #(
  parameter MAX_BITS = 12,
  parameter [7:0] ACQ_CYC = 8'h10
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire start_in,
  input wire discharge_out,
  input wire sample_out,
  input wire [MAX_BITS-1:0] cap_ref_out,
  input wire done_out,
  input wire busy_out
);
  int acq_cnt;
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acq_cnt <= 0;
    end else begin
      acq_cnt <= sample_out ? acq_cnt + 1 : 0;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence seq_ground;
    cap_ref_out == 0 ##1 $onehot(cap_ref_out);
  endsequence
  sequence seq_start_pending;
    start_in && !busy_out ##1 !busy_out ##1 !busy_out;
  endsequence
  chk_disch_start: assert property (
    seq_start_pending |=> discharge_out && busy_out) else $error("no discharge");
  chk_disch_excl: assert property (
    discharge_out |-> !sample_out && cap_ref_out == 0) else $error("discharge overlap");
  chk_acq_follows: assert property (
    $fell(discharge_out) |-> sample_out) else $error("no acquisition");
  chk_acq_len: assert property (
    $fell(sample_out) |-> acq_cnt == ACQ_CYC) else $error("acquisition length");
  chk_ground_first: assert property (
    $fell(sample_out) |-> seq_ground) else $error("no ground cycle");
  chk_trial_count: assert property (
    $fell(sample_out) |-> ##[9:13] done_out) else $error("trial count");
  chk_done_pulse: assert property (
    done_out |=> !done_out && !busy_out) else $error("done not one cycle");
  chk_done_busy: assert property (
    done_out |-> busy_out) else $error("done outside busy");
endmodule
bind sarseq_top sarseq_top_props #(.MAX_BITS(MAX_BITS), .ACQ_CYC(ACQ_CYC)) props_inst (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in),
  .discharge_out(discharge_out), .sample_out(sample_out), .cap_ref_out(cap_ref_out),
  .done_out(done_out), .busy_out(busy_out));
`default_nettype wire

// ==== tb/sarseq_analog_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sarseq_analog_model (
  input wire logic [11:0] cap_ref_in,
  input wire logic [11:0] level_in,
  output logic comp_out
);
  // input held as a code; trial level is the sum of weights on reference
  assign comp_out = (level_in >= cap_ref_in);
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_in = 0, sys_rst_in = 1, start_in = 0, comp_in, discharge_out, sample_out;
  logic done_out, busy_out;
  logic [1:0] res_sel_in = 2'h0;
  logic [11:0] cap_ref_out, result_out, level = 12'h000;
  int miscompares = 0, comparisons = 0;
  always #5 clk_in = ~clk_in;
  sarseq_top #(.ACQ_CYC(8'h04)) sarseq_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .start_in(start_in), .res_sel_in(res_sel_in), .comp_in(comp_in),
    .discharge_out(discharge_out), .sample_out(sample_out), .cap_ref_out(cap_ref_out),
    .result_out(result_out), .done_out(done_out), .busy_out(busy_out));
  sarseq_analog_model sarseq_analog_model_inst (.cap_ref_in(cap_ref_out), .level_in(level),
    .comp_out(comp_in));
  task check(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Latency counted from the start edge: 2 sync, 1 idle, 1 discharge, 4 acquire, ground, N trials
  task run(input logic [1:0] sel, input int n, input logic [11:0] lvl);
    int cnt;
    @(negedge clk_in);
    res_sel_in = sel;
    level = lvl & ((12'h001 << n) - 12'h001);
    start_in = 1;
    @(negedge clk_in);
    start_in = 0;
    cnt = 1;
    while (done_out !== 1'b1 && cnt < 100) begin
      @(negedge clk_in);
      cnt++;
    end
    check("latency", 12'(n + 9), 12'(cnt));
    check("result", level, result_out);
  endtask
  task t_modes;
    run(2'h0, 8, 12'hA5C);
    run(2'h1, 10, 12'hA5C);
    run(2'h2, 12, 12'hA5C);
    run(2'h3, 12, 12'h3A7);
  endtask
  task t_extremes;
    run(2'h2, 12, 12'h000);
    run(2'h2, 12, 12'hFFF);
    run(2'h0, 8, 12'h080);
    run(2'h1, 10, 12'h1FF);
  endtask
  task results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 0;
    t_modes();
    t_extremes();
    results();
  end
  // Whole run needs under 300 cycles
  initial begin
    #20000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
